// File: ksr_keyboard_responder.sv
// Keyboard side of the host link: scan codes, typematic, command replies.
// Assumes key events on i_mclk and a free-running link clock i_link_clk.
// Functional notes
// - Key down sends make, release sends break; pause sends make only.
// - A held key other than pause repeats its make code at a fixed rate.
// - Only the most recently pressed held key repeats.
// - Unknown closure or overrun sends 00h, or FFh in set one.
// - Passing self test sends AAh.
// - Failing self test sends FCh.
// - Echo command is answered with EEh, not acknowledge.
// - Valid host input is acknowledged with FAh, except echo and resend.
// - Invalid host input is answered with FEh.
// - Read ID answers acknowledge then two identity bytes.
// - F0h then 01h selects set one.
// - Set two is active after reset; each set has its own codes.
// - Set two break is F0h followed by the make code.
// - Split key with left alt, ctrl, shift held steps among three modes.
// - Each byte to the host is an eleven-bit frame.
// - Clock held low inhibits; pending bytes wait and go later.
// - Sixteen-byte queue; overflow puts overrun code, later data dropped.
`timescale 1ns/1ps
`include "ksr_map.svh"
module ksr_keyboard_responder import ksr_pkg::*; #(
	parameter int TYP_DELAY_CYC = `KSR_TYP_DELAY_MS * `KSR_MCLK_KHZ,
	parameter int TYP_RATE_CYC = `KSR_TYP_RATE_MS * `KSR_MCLK_KHZ,
	parameter logic [15:0] ID_CODE = `KSR_ID_DEFAULT
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_link_clk,
	input wire logic i_key_valid,
	output logic o_key_ready,
	input wire logic i_key_down,
	input wire logic i_key_pause,
	input wire logic i_key_split,
	input wire logic i_key_error,
	input wire logic [7:0] i_code1,
	input wire logic [7:0] i_code2,
	input wire logic [7:0] i_code3,
	input wire logic i_lalt,
	input wire logic i_lctrl,
	input wire logic i_lshift,
	input wire logic i_selftest_done,
	input wire logic i_selftest_pass,
	input wire logic i_kclk_i,
	output logic o_kclk_o,
	output logic o_kclk_oe,
	input wire logic i_kdat_i,
	output logic o_kdat_o,
	output logic o_kdat_oe,
	output ksr_pkg::ksr_set_t o_scan_set,
	output logic [1:0] o_split_mode,
	output logic o_disabled
);
	import ksr_pkg::*;
	localparam int HALF = `KSR_HALF_CYC;
	ksr_main_t m_q;
	ksr_main_t m_d;
	ksr_link_t l_q;
	ksr_link_t l_d;
	logic lrst_s1;
	logic lrst;
	logic push;
	logic pop;
	logic [7:0] push_b;
	logic f_rdy;
	logic f_valid;
	logic [7:0] f_data;
	logic [4:0] f_cnt;
	logic rx_new;
	logic busy;
	logic take;
	logic typ_fire;
	logic snd;
	logic [7:0] snd_b;
	logic [7:0] mk;
	logic [7:0] ovr;
	logic [7:0] b0;
	logic [1:0] len;
	logic [3:0] nb;

	// Make code of the active set
	function automatic logic [7:0] make_byte(input logic [1:0] s,
		input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
		case (s)
			`KSR_SET1: make_byte = c1;
			`KSR_SET3: make_byte = c3;
			default: make_byte = c2;
		endcase
	endfunction

	ksr_fifo #(.WIDTH(8), .DEPTH(`KSR_QDEPTH)) u_queue (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_valid(push),
		.o_ready(f_rdy),
		.i_data(push_b),
		.o_valid(f_valid),
		.i_ready(pop),
		.o_data(f_data),
		.o_count(f_cnt)
	);

	// Main domain: key events, queue, replies, byte hand-off to the link
	always_comb begin
		m_d = m_q;
		push = 1'b0;
		push_b = 8'h00;
		pop = 1'b0;
		snd = 1'b0;
		snd_b = 8'h00;
		len = 2'h1;
		rx_new = m_q.rx_s2 != m_q.rx_seen;
		busy = m_q.tx_req != m_q.ack_s2;
		ovr = (m_q.set == `KSR_SET1) ? `KSR_OVR_S1 : `KSR_OVR_S23;
		mk = make_byte(m_q.set, i_code1, i_code2, i_code3);
		take = i_key_valid && m_q.rdy && !m_q.dis;
		typ_fire = m_q.typ_v && m_q.typ_cnt == 25'h0;
		m_d.ack_s1 = l_q.ack_tog;
		m_d.ack_s2 = m_q.ack_s1;
		m_d.rx_s1 = l_q.rx_tog;
		m_d.rx_s2 = m_q.rx_s1;
		// Second byte of a break follows at once
		if (m_q.pend_v && f_rdy) begin
			push = 1'b1;
			push_b = m_q.pend_b;
			m_d.pend_v = 1'b0;
		end
		// Overrun ends only once the queue has drained
		if (f_cnt == 5'h0 && !m_q.pend_v) begin
			m_d.lost = 1'b0;
		end
		if (m_q.typ_v && !typ_fire) begin
			m_d.typ_cnt = m_q.typ_cnt - 25'h1;
		end
		// Replies first, repeats only between whole sequences
		if (!busy) begin
			if (m_q.resp_n != 2'h0) begin
				snd = 1'b1;
				snd_b = m_q.resp_q[23:16];
				m_d.resp_q = {m_q.resp_q[15:0], 8'h00};
				m_d.resp_n = m_q.resp_n - 2'h1;
			end else if (typ_fire && !f_valid && !m_q.pend_v) begin
				snd = 1'b1;
				snd_b = m_q.typ_b;
				m_d.typ_cnt = 25'(TYP_RATE_CYC);
			end else if (f_valid) begin
				snd = 1'b1;
				pop = 1'b1;
				snd_b = f_data;
			end
		end
		if (snd) begin
			m_d.tx_req = !m_q.tx_req;
			m_d.tx_data = snd_b;
			m_d.last_b = snd_b;
		end
		// Byte sequence of this event
		if (i_key_down) begin
			b0 = mk;
		end else if (m_q.set == `KSR_SET1) begin
			b0 = i_code1 | `KSR_BRK_S1;
		end else begin
			b0 = `KSR_BRK_PFX;
			len = 2'h2;
		end
		if (!i_key_down && i_key_pause) begin
			len = 2'h0;
		end
		// One slot stays free so the overrun code always fits
		if (take && !m_q.lost) begin
			if (i_key_error) begin
				push = f_rdy;
				push_b = ovr;
			end else if (6'(f_cnt) + 6'(len) > 6'(`KSR_QDEPTH - 1)) begin
				push = 1'b1;
				push_b = ovr;
				m_d.lost = 1'b1;
			end else if (len != 2'h0) begin
				push = 1'b1;
				push_b = b0;
				m_d.pend_v = len == 2'h2;
				m_d.pend_b = mk;
			end
		end
		// Repeat follows the newest key only
		if (take && !i_key_error) begin
			if (i_key_down && !i_key_pause) begin
				m_d.typ_v = 1'b1;
				m_d.typ_key = i_code2;
				m_d.typ_b = mk;
				m_d.typ_cnt = 25'(TYP_DELAY_CYC);
			end else if (!i_key_down && i_code2 == m_q.typ_key) begin
				m_d.typ_v = 1'b0;
			end
			if (i_key_down && i_key_split && i_lalt && i_lctrl && i_lshift) begin
				m_d.split = (m_q.split == 2'h2) ? 2'h0 : m_q.split + 2'h1;
			end
		end
		m_d.rdy = !m_d.pend_v;
		// Host commands; any input except F5h lifts a failed-test disable
		if (rx_new) begin
			m_d.rx_seen = m_q.rx_s2;
			m_d.dis = 1'b0;
			m_d.resp_n = 2'h1;
			m_d.resp_q = {`KSR_ACK, 16'h0000};
			if (l_q.rx_err) begin
				m_d.resp_q = {`KSR_RESEND, 16'h0000};
			end else if (m_q.wait_opt) begin
				m_d.wait_opt = 1'b0;
				if (l_q.rx_data >= 8'h01 && l_q.rx_data <= 8'h03) begin
					m_d.set = l_q.rx_data[1:0];
				end else begin
					m_d.resp_q = {`KSR_RESEND, 16'h0000};
				end
			end else begin
				case (l_q.rx_data)
					`KSR_CMD_ECHO: m_d.resp_q = {`KSR_ECHO, 16'h0000};
					`KSR_CMD_RESEND: m_d.resp_q = {m_q.last_b, 16'h0000};
					`KSR_CMD_READ_ID: begin
						m_d.resp_q = {`KSR_ACK, ID_CODE};
						m_d.resp_n = 2'h3;
					end
					`KSR_CMD_SET: m_d.wait_opt = 1'b1;
					`KSR_CMD_ENABLE: m_d.dis = 1'b0;
					`KSR_CMD_DISABLE: m_d.dis = 1'b1;
					`KSR_CMD_RESET: begin
						m_d.resp_q = {`KSR_ACK, `KSR_BAT_OK, 8'h00};
						m_d.resp_n = 2'h2;
						m_d.set = `KSR_SET2;
						m_d.typ_v = 1'b0;
					end
					default: m_d.resp_q = {`KSR_RESEND, 16'h0000};
				endcase
			end
		end
		// Self-test outcome; a failure leaves the keyboard disabled
		if (i_selftest_done) begin
			m_d.resp_q = {i_selftest_pass ? `KSR_BAT_OK : `KSR_BAT_FAIL,
				16'h0000};
			m_d.resp_n = 2'h1;
			m_d.dis = !i_selftest_pass;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			m_q <= '{set: `KSR_SET2, rdy: 1'b1, default: '0};
		end else begin
			m_q <= m_d;
		end
	end

	// Reset brought into the link domain
	always_ff @(posedge i_link_clk) begin
		lrst_s1 <= i_reset;
		lrst <= lrst_s1;
	end

	// Link domain: frame engine in both directions
	always_comb begin
		l_d = l_q;
		nb = l_q.bitn + 4'h1;
		l_d.kclk_s1 = i_kclk_i;
		l_d.kclk_s2 = l_q.kclk_s1;
		l_d.kdat_s1 = i_kdat_i;
		l_d.kdat_s2 = l_q.kdat_s1;
		l_d.req_s1 = m_q.tx_req;
		l_d.req_s2 = l_q.req_s1;
		l_d.div = l_q.div + 9'h1;
		case (l_q.st)
			KSR_LK_IDLE: begin
				l_d.div = 9'h0;
				l_d.ph = 1'b0;
				l_d.bitn = 4'h0;
				if (l_q.kclk_s2 && !l_q.kdat_s2) begin
					l_d.st = KSR_LK_RX;
				end else if (l_q.kclk_s2 && l_q.req_s2 != l_q.req_seen) begin
					l_d.st = KSR_LK_TX;
					l_d.sh = {1'b1, ~^m_q.tx_data, m_q.tx_data, 1'b0};
					l_d.dat_oe = 1'b1;
				end
			end
			KSR_LK_TX, KSR_LK_RX: begin
				if (l_q.div == 9'(HALF - 1)) begin
					l_d.div = 9'h0;
					if (!l_q.ph) begin
						l_d.clk_oe = 1'b1;
						l_d.ph = 1'b1;
						if (l_q.st == KSR_LK_RX) begin
							l_d.sh[l_q.bitn] = l_q.kdat_s2;
						end else if (l_q.bitn <= 4'h9 && !l_q.kclk_s2) begin
							// Inhibit up to and during the parity bit: drop the frame, retry later
							l_d.st = KSR_LK_IDLE;
							l_d.clk_oe = 1'b0;
							l_d.dat_oe = 1'b0;
						end
					end else begin
						l_d.clk_oe = 1'b0;
						l_d.ph = 1'b0;
						if (l_q.bitn == 4'(`KSR_FRAME_BITS - 1)) begin
							l_d.st = KSR_LK_IDLE;
							l_d.dat_oe = 1'b0;
							if (l_q.st == KSR_LK_TX) begin
								l_d.ack_tog = !l_q.ack_tog;
								l_d.req_seen = l_q.req_s2;
							end else begin
								l_d.rx_data = l_q.sh[7:0];
								l_d.rx_err = (~^l_q.sh[7:0] != l_q.sh[8]) || !l_q.sh[9];
								l_d.rx_tog = !l_q.rx_tog;
							end
						end else begin
							l_d.bitn = nb;
							l_d.dat_oe = (l_q.st == KSR_LK_TX) ? !l_q.sh[nb] :
								nb == 4'(`KSR_FRAME_BITS - 1);
						end
					end
				end
			end
			default: l_d.st = KSR_LK_IDLE;
		endcase
	end

	always_ff @(posedge i_link_clk) begin
		if (lrst) begin
			l_q <= '{st: KSR_LK_IDLE, default: '0};
		end else begin
			l_q <= l_d;
		end
	end

	assign o_key_ready = m_q.rdy;
	assign o_scan_set = m_q.set;
	assign o_split_mode = m_q.split;
	assign o_disabled = m_q.dis;
	assign o_kclk_o = l_q.lo;
	assign o_kdat_o = l_q.lo;
	assign o_kclk_oe = l_q.clk_oe;
	assign o_kdat_oe = l_q.dat_oe;

	// Checks in the main domain
	pause_make_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		take && !i_key_down && i_key_pause && !i_key_error |-> !push)
		else $error("pause release pushed a byte");
	set1_break_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		take && !i_key_down && !i_key_pause && !i_key_error && !m_q.lost &&
		m_q.set == `KSR_SET1 && f_cnt < 5'hF |-> push && push_b == (i_code1 | 8'h80))
		else $error("set one break code wrong");
	typ_repeat_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		!busy && m_q.resp_n == 2'h0 && typ_fire && !f_valid && !m_q.pend_v
		|=> $changed(m_q.tx_req) && m_q.tx_data == $past(m_q.typ_b))
		else $error("typematic byte not sent");
	typ_latest_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		take && i_key_down && !i_key_pause && !i_key_error
		|=> m_q.typ_v && m_q.typ_key == $past(i_code2))
		else $error("newest key not typematic");
	overrun_code_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		take && i_key_error && !m_q.lost && f_rdy |-> push &&
		push_b == ((m_q.set == `KSR_SET1) ? 8'hFF : 8'h00))
		else $error("wrong detection error code");
	self_test_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_selftest_done |=> m_q.resp_n == 2'h1 && m_q.resp_q[23:16] ==
		($past(i_selftest_pass) ? 8'hAA : 8'hFC))
		else $error("self test reply wrong");
	echo_reply_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		rx_new && !l_q.rx_err && !m_q.wait_opt && l_q.rx_data == 8'hEE &&
		!i_selftest_done |=> m_q.resp_q[23:16] == 8'hEE)
		else $error("echo not answered");
	ack_reply_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		rx_new && !l_q.rx_err && !m_q.wait_opt && l_q.rx_data == 8'hF4 &&
		!i_selftest_done |=> m_q.resp_q[23:16] == 8'hFA && m_q.resp_n == 2'h1)
		else $error("valid input not acknowledged");
	bad_input_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		rx_new && l_q.rx_err && !i_selftest_done |=> m_q.resp_q[23:16] == 8'hFE)
		else $error("invalid input not refused");
	read_id_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		rx_new && !l_q.rx_err && !m_q.wait_opt && l_q.rx_data == 8'hF2 &&
		!i_selftest_done |=> m_q.resp_q == {8'hFA, ID_CODE} && m_q.resp_n == 2'h3)
		else $error("identity reply wrong");
	set_select_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		rx_new && !l_q.rx_err && m_q.wait_opt && l_q.rx_data == 8'h01
		|=> m_q.set == 2'h1)
		else $error("set one not selected");
	default_set_a: assert property (@(posedge i_mclk)
		i_reset |=> m_q.set == 2'h2)
		else $error("set two not default");
	break_pfx_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		push && push_b == 8'hF0 && take && !i_key_down && m_q.set != 2'h1
		|=> m_q.pend_v && m_q.pend_b == $past(mk))
		else $error("break make byte not queued");
	split_step_a: assert property (@(posedge i_mclk) disable iff (i_reset)
		take && !i_key_error && i_key_down && i_key_split && i_lalt && i_lctrl &&
		i_lshift |=> m_q.split == (($past(m_q.split) == 2'h2) ? 2'h0 :
		$past(m_q.split) + 2'h1))
		else $error("split mode not stepped");
	// Checks in the link domain
	inhibit_a: assert property (@(posedge i_link_clk) disable iff (lrst)
		l_q.st == KSR_LK_IDLE && !l_q.kclk_s2 |=> l_q.st == KSR_LK_IDLE)
		else $error("frame started while inhibited");
	frame_end_a: assert property (@(posedge i_link_clk) disable iff (lrst)
		l_q.st == KSR_LK_TX && l_q.ph && l_q.div == 9'(HALF - 1) && l_q.bitn == 4'hA
		|=> $changed(l_q.ack_tog) && !l_q.dat_oe)
		else $error("frame not ended after eleven bits");
endmodule // ksr_keyboard_responder

// File: ksr_map.svh
// Constants of the keyboard scan-code responder: byte codes, sets, timing.
// Assumes a 40 MHz main clock and an 8 MHz link clock.
`ifndef KSR_MAP_SVH
`define KSR_MAP_SVH
// Bytes sent to the host
`define KSR_ACK 8'hFA
`define KSR_RESEND 8'hFE
`define KSR_ECHO 8'hEE
`define KSR_BAT_OK 8'hAA
`define KSR_BAT_FAIL 8'hFC
`define KSR_OVR_S1 8'hFF
`define KSR_OVR_S23 8'h00
`define KSR_BRK_PFX 8'hF0
`define KSR_BRK_S1 8'h80
// Host command bytes
`define KSR_CMD_ECHO 8'hEE
`define KSR_CMD_RESEND 8'hFE
`define KSR_CMD_READ_ID 8'hF2
`define KSR_CMD_SET 8'hF0
`define KSR_CMD_ENABLE 8'hF4
`define KSR_CMD_DISABLE 8'hF5
`define KSR_CMD_RESET 8'hFF
// Scan-code sets
`define KSR_SET1 2'h1
`define KSR_SET2 2'h2
`define KSR_SET3 2'h3
// Arbitrary identity value, not a real product code
`define KSR_ID_DEFAULT 16'h5A3C
// Queue and frame
`define KSR_QDEPTH 16
`define KSR_FRAME_BITS 11
// Timing
`define KSR_MCLK_KHZ 40000
`define KSR_LINK_KHZ 8000
`define KSR_TYP_DELAY_MS 500
`define KSR_TYP_RATE_MS 100
`define KSR_HALF_US 40
`define KSR_HALF_CYC (`KSR_HALF_US * `KSR_LINK_KHZ / 1000)
`endif

// File: ksr_pkg.sv
// Types of the keyboard scan-code responder.
// Assumes ksr_map.svh is on the include path.
`include "ksr_map.svh"
package ksr_pkg;
	typedef logic [1:0] ksr_set_t;
	typedef enum logic [1:0] {
		KSR_LK_IDLE = 2'h0,
		KSR_LK_TX = 2'h1,
		KSR_LK_RX = 2'h2
	} ksr_link_st_t;
	typedef struct packed {
		ksr_set_t set;
		logic [1:0] split;
		logic dis;
		logic lost;
		logic rdy;
		logic pend_v;
		logic [7:0] pend_b;
		logic typ_v;
		logic [7:0] typ_key;
		logic [7:0] typ_b;
		logic [24:0] typ_cnt;
		logic [23:0] resp_q;
		logic [1:0] resp_n;
		logic wait_opt;
		logic [7:0] last_b;
		logic tx_req;
		logic [7:0] tx_data;
		logic ack_s1;
		logic ack_s2;
		logic rx_s1;
		logic rx_s2;
		logic rx_seen;
	} ksr_main_t;
	typedef struct packed {
		ksr_link_st_t st;
		logic ph;
		logic [8:0] div;
		logic [3:0] bitn;
		logic [10:0] sh;
		logic kclk_s1;
		logic kclk_s2;
		logic kdat_s1;
		logic kdat_s2;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ack_tog;
		logic rx_tog;
		logic [7:0] rx_data;
		logic rx_err;
		logic clk_oe;
		logic dat_oe;
		logic lo;
	} ksr_link_t;
endpackage

// File: ksr_fifo.sv
// Scan-code queue: first-word-fall-through FIFO with valid/ready.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/1ps
module ksr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} ksr_fifo_t;
	ksr_fifo_t q;
	ksr_fifo_t d;
	logic push;
	logic pop;

	// Flags straight from the count, so full and empty are exact
	assign o_ready = q.cnt != CW'(DEPTH);
	assign o_valid = q.cnt != '0;
	assign o_data = q.mem[q.rd];
	assign o_count = q.cnt;

	// Pointer and count update
	always_comb begin
		d = q;
		push = i_valid && o_ready;
		pop = o_valid && i_ready;
		if (push) begin
			d.mem[q.wr] = i_data;
			d.wr = q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = q.rd + 1'b1;
		end
		d.cnt = q.cnt + CW'(push) - CW'(pop);
	end

	// State register
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // ksr_fifo

// File: ksr_host_model.sv
// Host-side keyboard controller model: pulls up both lines, can inhibit
// the link clock, and captures device-to-host frames on falling clocks.
// Assumes the device drives each line low only while its enable is high.
`timescale 1ns/1ps
module ksr_host_model (
	input wire logic i_clk_oe,
	input wire logic i_dat_oe,
	input wire logic i_inhibit,
	output logic o_kclk,
	output logic o_kdat,
	output int o_rx_cnt,
	output logic [7:0] o_rx_last,
	output logic o_rx_ok
);
	logic [10:0] sh;
	int n;

	// Open-drain lines with pull-ups; holding the clock low inhibits
	assign o_kclk = !(i_clk_oe || i_inhibit);
	assign o_kdat = !i_dat_oe;

	// Nothing captured before the first frame
	initial begin
		n = 0;
		sh = '0;
		o_rx_cnt = 0;
		o_rx_last = 8'h00;
		o_rx_ok = 1'b0;
	end

	// Data is sampled while the device holds the clock low; an inhibit
	// throws away any partly received frame
	always @(negedge o_kclk or posedge i_inhibit) begin
		if (i_inhibit) begin
			n = 0;
		end else begin
			sh[n] = o_kdat;
			n = n + 1;
			// Start 0, eight data bits LSB first, odd parity, stop 1
			if (n == 11) begin
				n = 0;
				o_rx_ok = !sh[0] && (^sh[9:1]) && sh[10];
				// Raw bytes kept, no translation of the code set
				o_rx_last = sh[8:1];
				o_rx_cnt = o_rx_cnt + 1;
			end
		end
	end
endmodule // ksr_host_model

// File: keyboard_scan_code_responder_tb.sv
// Self-checking bench for the keyboard scan-code responder.
// Assumes ksr_map.svh on the include path; each byte on the link takes
// about 35,000 main clocks, so only a few frames are exercised.
`timescale 1ns/1ps
`include "ksr_map.svh"
module keyboard_scan_code_responder_tb;
	import ksr_pkg::*;
	logic i_mclk = 1'b0;
	logic i_link_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_key_valid = 1'b0;
	logic i_key_down = 1'b0;
	logic i_key_pause = 1'b0;
	logic i_key_split = 1'b0;
	logic i_key_error = 1'b0;
	logic i_lalt = 1'b0;
	logic i_lctrl = 1'b0;
	logic i_lshift = 1'b0;
	logic [7:0] i_code1 = 8'h00;
	logic [7:0] i_code2 = 8'h00;
	logic [7:0] i_code3 = 8'h00;
	logic i_selftest_done = 1'b0;
	logic i_selftest_pass = 1'b0;
	logic inhibit = 1'b0;
	logic o_key_ready, o_kclk_o, o_kclk_oe, o_kdat_o, o_kdat_oe;
	logic o_disabled;
	logic [1:0] o_split_mode;
	ksr_set_t o_scan_set;
	logic kclk, kdat, rx_ok;
	logic [7:0] rx_last;
	int rx_cnt;
	int miscompares = 0;
	int cmp_count = 0;

	// Main clock 40 MHz; link clock 125 ns with an odd phase offset
	always #12.5 i_mclk = ~i_mclk;
	initial begin
		#3.1;
		forever #62.5 i_link_clk = ~i_link_clk;
	end

	// Short typematic counts keep the run brief
	ksr_keyboard_responder #(.TYP_DELAY_CYC(200), .TYP_RATE_CYC(50))
	u_ksr_keyboard_responder (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_link_clk(i_link_clk), .i_key_valid(i_key_valid),
		.o_key_ready(o_key_ready), .i_key_down(i_key_down),
		.i_key_pause(i_key_pause), .i_key_split(i_key_split),
		.i_key_error(i_key_error), .i_code1(i_code1), .i_code2(i_code2),
		.i_code3(i_code3), .i_lalt(i_lalt), .i_lctrl(i_lctrl),
		.i_lshift(i_lshift), .i_selftest_done(i_selftest_done),
		.i_selftest_pass(i_selftest_pass), .i_kclk_i(kclk),
		.o_kclk_o(o_kclk_o), .o_kclk_oe(o_kclk_oe), .i_kdat_i(kdat),
		.o_kdat_o(o_kdat_o), .o_kdat_oe(o_kdat_oe),
		.o_scan_set(o_scan_set), .o_split_mode(o_split_mode),
		.o_disabled(o_disabled));

	ksr_host_model u_ksr_host_model (.i_clk_oe(o_kclk_oe),
		.i_dat_oe(o_kdat_oe), .i_inhibit(inhibit), .o_kclk(kclk),
		.o_kdat(kdat), .o_rx_cnt(rx_cnt), .o_rx_last(rx_last),
		.o_rx_ok(rx_ok));

	// Verdict and end of run, also reached by a timeout
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Compare one value with its expectation
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bounded wait until the host has taken a given number of bytes
	task automatic wait_bytes(input int target);
		int k;
		k = 0;
		while (rx_cnt < target && k < 45000) begin
			@(negedge i_mclk);
			k++;
		end
		if (rx_cnt < target) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, rx_cnt, target);
			complete_run();
		end
	endtask

	// One key event, offered only while the block is ready
	task automatic key_evt(input logic down, input logic pause,
		input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
		int k;
		k = 0;
		@(negedge i_mclk);
		while (o_key_ready !== 1'b1 && k < 100) begin
			@(negedge i_mclk);
			k++;
		end
		check(16'(o_key_ready), 16'h0001);
		if (o_key_ready !== 1'b1) begin
			complete_run();
		end
		i_key_valid = 1'b1;
		i_key_down = down;
		i_key_pause = pause;
		i_code1 = c1;
		i_code2 = c2;
		i_code3 = c3;
		@(negedge i_mclk);
		i_key_valid = 1'b0;
	endtask

	// Outputs after reset: set two, no split mode, lines released
	task automatic t_reset_state();
		check(16'(o_scan_set), 16'(`KSR_SET2));
		check(16'(o_split_mode), 16'h0000);
		check(16'(o_disabled), 16'h0000);
		check(16'({o_kclk_oe, o_kdat_oe}), 16'h0000);
		check(16'({o_kclk_o, o_kdat_o}), 16'h0000);
		$display("Test reset_state finished");
	endtask

	// Passing self test is reported with one framed byte
	task automatic t_selftest();
		@(negedge i_mclk);
		i_selftest_done = 1'b1;
		i_selftest_pass = 1'b1;
		@(negedge i_mclk);
		i_selftest_done = 1'b0;
		wait_bytes(1);
		check(16'(rx_last), 16'(`KSR_BAT_OK));
		check(16'(rx_ok), 16'h0001);
		check(16'(o_disabled), 16'h0000);
		$display("Test selftest finished");
	endtask

	// Releasing the pause key sends nothing
	task automatic t_pause_release();
		key_evt(1'b0, 1'b1, 8'h45, 8'h77, 8'h62);
		repeat (2000) @(negedge i_mclk);
		check(16'(rx_cnt), 16'h0001);
		check(16'(o_kdat_oe), 16'h0000);
		$display("Test pause_release finished");
	endtask

	// Break held back by inhibit, then sent whole as prefix and make
	task automatic t_inhibit_break();
		@(negedge i_mclk);
		inhibit = 1'b1;
		key_evt(1'b0, 1'b0, 8'h1E, 8'h1C, 8'h1C);
		repeat (4000) @(negedge i_mclk);
		check(16'(rx_cnt), 16'h0001);
		check(16'({o_kclk_oe, o_kdat_oe}), 16'h0000);
		inhibit = 1'b0;
		wait_bytes(2);
		check(16'(rx_last), 16'(`KSR_BRK_PFX));
		check(16'(rx_ok), 16'h0001);
		wait_bytes(3);
		check(16'(rx_last), 16'h001C);
		check(16'(rx_ok), 16'h0001);
		$display("Test inhibit_break finished");
	endtask

	// Split key with all three left modifiers steps 0, 1, 2, back to 0;
	// no step with one modifier up. Bytes left queued are not awaited,
	// since each frame costs tens of thousands of main clocks.
	task automatic t_split_mode();
		i_lalt = 1'b1;
		i_lctrl = 1'b1;
		i_lshift = 1'b1;
		i_key_split = 1'b1;
		key_evt(1'b1, 1'b0, 8'h0E, 8'h66, 8'h66);
		check(16'(o_split_mode), 16'h0001);
		key_evt(1'b1, 1'b0, 8'h0E, 8'h66, 8'h66);
		check(16'(o_split_mode), 16'h0002);
		key_evt(1'b1, 1'b0, 8'h0E, 8'h66, 8'h66);
		check(16'(o_split_mode), 16'h0000);
		i_lshift = 1'b0;
		key_evt(1'b1, 1'b0, 8'h0E, 8'h66, 8'h66);
		check(16'(o_split_mode), 16'h0000);
		i_key_split = 1'b0;
		i_lalt = 1'b0;
		i_lctrl = 1'b0;
		// Unknown closure queues a single byte, nothing left pending
		i_key_error = 1'b1;
		key_evt(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
		i_key_error = 1'b0;
		check(16'(o_key_ready), 16'h0001);
		$display("Test split_mode finished");
	endtask

	// Reset for 20 cycles, then the scenarios in turn
	initial begin
		repeat (20) @(negedge i_mclk);
		i_reset = 1'b0;
		repeat (40) @(negedge i_mclk);
		t_reset_state();
		t_selftest();
		t_pause_release();
		t_inhibit_break();
		t_split_mode();
		complete_run();
	end
endmodule // keyboard_scan_code_responder_tb
